// >>> dv/dmm_asserts.sv
// checker of the memory map block: answer timing, decoding, stack, banks
// bound to dmm_top; sees only its ports
`timescale 1ns/1ps
module dmm_asserts #(
   parameter bit LARGE = 1'b0
) (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        acc_req,
   input wire logic [2:0]  acc_kind,
   input wire logic [7:0]  acc_addr,
   input wire logic        acc_valid,
   input wire logic        sp_we,
   input wire logic [7:0]  stack_pointer,
   input wire logic        periph_req,
   input wire logic [7:0]  periph_addr,
   input wire logic        xdata_req,
   input wire logic [15:0] xdata_addr,
   input wire logic        ext_data_req,
   input wire logic [15:0] ext_data_addr,
   input wire logic        fetch_req,
   input wire logic [15:0] fetch_addr,
   input wire logic        onchip_enable,
   input wire logic        prog_onchip_sel,
   input wire logic        prog_external_sel,
   input wire logic        psw_we,
   input wire logic [7:0]  psw_wdata,
   input wire logic [1:0]  active_bank
);
   localparam int PROG_LIM = 1024 * (LARGE ? dmm_pkg::ONCHIP_LARGE_KB
                                           : dmm_pkg::ONCHIP_SMALL_KB);
   logic [1:0] psw_bank;
   logic       fetch_on;
   // helper terms for bank select and on-chip fetch range
   assign psw_bank = psw_wdata[4:3];
   assign fetch_on = onchip_enable && (fetch_addr < PROG_LIM);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_push; acc_req && acc_kind == 3'h4 && !sp_we; endsequence
   sequence s_pop;  acc_req && acc_kind == 3'h5 && !sp_we; endsequence
   property p_latency; acc_req |-> ##2 acc_valid; endproperty
   property p_direct_periph;
      acc_req && acc_kind == 3'h0 && acc_addr[7]
         |=> periph_req && periph_addr == $past(acc_addr);
   endproperty
   property p_indirect_ram;
      LARGE && acc_req && acc_kind inside {3'h1, 3'h4, 3'h5} |=> !periph_req;
   endproperty
   property p_push; s_push |=> stack_pointer == $past(stack_pointer) + 8'h01;
   endproperty
   property p_pop; s_pop |=> stack_pointer == $past(stack_pointer) - 8'h01;
   endproperty
   property p_xdata;
      xdata_req |=> ext_data_req && ext_data_addr == $past(xdata_addr);
   endproperty
   property p_xquiet; !xdata_req |=> !ext_data_req; endproperty
   property p_bank; psw_we |=> active_bank == $past(psw_bank); endproperty
   property p_prog;
      fetch_req |=> prog_onchip_sel == $past(fetch_on)
                    && prog_external_sel == !$past(fetch_on);
   endproperty
   a_latency: assert property (p_latency)
      else $error("answer not two cycles after request");
   a_direct_periph: assert property (p_direct_periph)
      else $error("direct upper access missed peripherals");
   a_indirect_ram: assert property (p_indirect_ram)
      else $error("indirect or stack access reached peripherals");
   a_push: assert property (p_push)
      else $error("push did not increment stack pointer");
   a_pop: assert property (p_pop)
      else $error("pop did not decrement stack pointer");
   a_xdata: assert property (p_xdata)
      else $error("external move not forwarded");
   a_xquiet: assert property (p_xquiet)
      else $error("external request without external move");
   a_bank: assert property (p_bank)
      else $error("active bank differs from status bits");
   a_prog: assert property (p_prog)
      else $error("program fetch routed wrongly");
endmodule

// >>> dv/dmm_ext_model.sv
// far side: peripheral register file and external data memory
// assumes one-cycle registered request pulses from the map block
`timescale 1ns/1ps
module dmm_ext_model (
   input  wire logic        sys_clk,
   input  wire logic        periph_req,
   input  wire logic        periph_write,
   input  wire logic [7:0]  periph_addr,
   input  wire logic [7:0]  periph_wdata,
   output logic      [7:0]  periph_rdata,
   input  wire logic        ext_data_req,
   input  wire logic        ext_data_write,
   input  wire logic [15:0] ext_data_addr,
   input  wire logic [7:0]  ext_data_wdata
);
   logic [7:0] pm [256];
   logic [7:0] xm [65536];
   // read data stands while periph_req does, inverted when idle
   assign periph_rdata = periph_req ? pm[periph_addr] : ~pm[periph_addr];
   // peripheral and external data stores
   always @(posedge sys_clk) begin
      if (periph_req && periph_write) pm[periph_addr] <= periph_wdata;
      if (ext_data_req && ext_data_write) xm[ext_data_addr] <= ext_data_wdata;
   end
endmodule

// >>> dv/tb.sv
// self-checking bench of the memory map block against a ram model
// assumes dmm_pkg, dmm_top, the far-side model and the checker
`timescale 1ns/1ps
module tb;
   localparam bit LARGE = 1'b1;
   localparam logic [15:0] FA [5] = '{16'h0000, 16'h1FFF, 16'h2000,
                                      16'hFFFF, 16'h0000};
   logic sys_clk = 1'b0, rstn = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
   logic acc_bit_val = 1'b0, xdata_req = 1'b0, xdata_write = 1'b0;
   logic fetch_req = 1'b0, onchip_enable = 1'b0, psw_we = 1'b0;
   logic sp_we = 1'b0;
   logic [2:0]  acc_kind = 3'h0;
   logic [7:0]  acc_addr = 8'h00, acc_wdata = 8'h00, psw_wdata = 8'h00;
   logic [7:0]  sp_wdata = 8'h00, xdata_wdata = 8'h00;
   logic [15:0] xdata_addr = 16'h0000, fetch_addr = 16'h0000;
   logic [7:0]  periph_rdata, acc_rdata, periph_addr, periph_wdata;
   logic [7:0]  ext_data_wdata, stack_pointer;
   logic [15:0] ext_data_addr;
   logic [2:0]  acc_region;
   logic [1:0]  active_bank;
   logic acc_valid, acc_bit_rdata, periph_req, periph_write, ext_data_req;
   logic ext_data_write, prog_onchip_sel, prog_external_sel;
   int error_cnt = 0, checked = 0, cyc = 0;
   int mem [256];
   dmm_top #(.LARGE(LARGE)) uut (.*);
   dmm_ext_model u_ext (.*);
   always #12.5 sys_clk = ~sys_clk;
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(string nm, int exp, logic [7:0] got);
      checked++;
      if (got !== exp[7:0]) begin
         error_cnt++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp[7:0], got);
      end
   endtask
   // one internal access, waiting a bounded time for the answer
   task automatic acc(logic [2:0] k, logic w, logic [7:0] a, logic [7:0] d);
      int n;
      @(posedge sys_clk);
      acc_kind <= k;
      acc_write <= w;
      acc_addr <= a;
      acc_wdata <= d;
      acc_bit_val <= d[0];
      acc_req <= 1'b1;
      @(posedge sys_clk);
      acc_req <= 1'b0;
      n = 0;
      while (n < 4 && acc_valid !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk("acc_valid", 1, {7'h00, acc_valid});
   endtask
   // status word or stack pointer load
   task automatic ld(logic s, logic [7:0] d);
      @(posedge sys_clk);
      psw_we <= !s;
      sp_we <= s;
      psw_wdata <= d;
      sp_wdata <= d;
      @(posedge sys_clk);
      psw_we <= 1'b0;
      sp_we <= 1'b0;
      #1;
   endtask
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      int v, b, x;
      logic [15:0] a;
      void'($urandom(24));
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk("stack_pointer", 8'h07, stack_pointer);
      chk("active_bank", 0, {6'h00, active_bank});
      for (int i = 0; i < 256; i++) begin
         mem[i] = $urandom_range(255);
         acc(3'h1, 1'b1, i[7:0], mem[i][7:0]);
      end
      for (int i = 0; i < 256; i++) begin
         acc(i < 128 ? 3'h0 : 3'h1, 1'b0, i[7:0], 8'h00);
         chk("ram", mem[i], acc_rdata);
         x = i < 32 ? dmm_pkg::DMM_REG_BANK
             : i < 48 ? dmm_pkg::DMM_REG_BITSEG
             : i < 128 ? dmm_pkg::DMM_REG_SCRATCH
             : dmm_pkg::DMM_REG_UPPER_RAM;
         chk("acc_region", x, {5'h00, acc_region});
      end
      acc(3'h0, 1'b1, 8'h80, 8'hAA);
      acc(3'h0, 1'b0, 8'h80, 8'h00);
      chk("periph", 8'hAA, acc_rdata);
      chk("region", dmm_pkg::DMM_REG_PERIPH, {5'h00, acc_region});
      acc(3'h1, 1'b0, 8'h80, 8'h00);
      chk("upper", mem[128], acc_rdata);
      for (int i = 0; i < 16; i++) begin
         b = (i == 0) ? 127 : $urandom_range(127);
         v = $urandom_range(1);
         x = 32 + b / 8;
         acc(3'h3, 1'b1, b[7:0], v[7:0]);
         mem[x][b % 8] = v[0];
         acc(3'h0, 1'b0, x[7:0], 8'h00);
         chk("bit_byte", mem[x], acc_rdata);
         acc(3'h3, 1'b0, b[7:0], 8'h00);
         chk("bit_read", v, {7'h00, acc_bit_rdata});
      end
      for (int k = 0; k < 4; k++) begin
         ld(1'b0, 8'(k << 3) | 8'($urandom_range(255)) & 8'hE7);
         chk("active_bank", k, {6'h00, active_bank});
         for (int r = 0; r < 8; r++) begin
            x = k * 8 + r;
            mem[x] = $urandom_range(255);
            acc(3'h2, 1'b1, r[7:0], mem[x][7:0]);
            acc(3'h0, 1'b0, x[7:0], 8'h00);
            chk("bank_reg", mem[x], acc_rdata);
         end
      end
      mem[8] = $urandom_range(255);
      acc(3'h4, 1'b1, 8'h00, mem[8][7:0]);
      chk("stack_pointer", 8'h08, stack_pointer);
      acc(3'h0, 1'b0, 8'h08, 8'h00);
      chk("push_dst", mem[8], acc_rdata);
      acc(3'h5, 1'b0, 8'h00, 8'h00);
      chk("pop", mem[8], acc_rdata);
      chk("stack_pointer", 8'h07, stack_pointer);
      ld(1'b1, 8'h7F);
      acc(3'h4, 1'b1, 8'h00, 8'h3C);
      acc(3'h1, 1'b0, 8'h80, 8'h00);
      chk("stack_upper", 8'h3C, acc_rdata);
      acc(3'h0, 1'b0, 8'h80, 8'h00);
      chk("periph_kept", 8'hAA, acc_rdata);
      // mid-run reset restores pointer and bank
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk("stack_pointer", 8'h07, stack_pointer);
      chk("active_bank", 0, {6'h00, active_bank});
      for (int i = 0; i < 4; i++) begin
         a = $urandom;
         v = $urandom_range(255);
         @(posedge sys_clk);
         xdata_req <= 1'b1;
         xdata_write <= 1'b1;
         xdata_addr <= a;
         xdata_wdata <= v[7:0];
         @(posedge sys_clk);
         xdata_req <= 1'b0;
         @(posedge sys_clk);
         #1;
         chk("xdata", v, u_ext.xm[a]);
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         fetch_req <= 1'b1;
         fetch_addr <= FA[i];
         onchip_enable <= (i < 4);
         @(posedge sys_clk);
         fetch_req <= 1'b0;
         #1;
         v = (i < 4) && (FA[i] < dmm_pkg::ONCHIP_LARGE_KB * 1024);
         chk("prog_onchip", v, {7'h00, prog_onchip_sel});
         chk("prog_external", 1 - v, {7'h00, prog_external_sel});
      end
      finish_test();
   end
endmodule
bind dmm_top dmm_asserts #(.LARGE(LARGE)) u_chk (.*);

// >>> verilog/dmm_pkg.sv
// package for the data memory address map block
// shared by the top and the program decoder leaf; no module assumptions
package dmm_pkg;
   localparam int          PROG_AW         = 16;
   localparam int          XDATA_AW        = 16;
   localparam int          RAM_AW          = 8;
   localparam int          ONCHIP_SMALL_KB = 4;
   localparam int          ONCHIP_LARGE_KB = 8;
   localparam logic [7:0]  SP_RESET        = 8'h07;
   localparam logic [7:0]  UPPER_BASE      = 8'h80;
   localparam logic [7:0]  BIT_SEG_BASE    = 8'h20;
   localparam logic [7:0]  BIT_SEG_LAST    = 8'h2F;
   localparam logic [7:0]  SCRATCH_BASE    = 8'h30;
   localparam logic [7:0]  BANK_LAST       = 8'h1F;
   localparam int          PSW_BANK_HI     = 4;
   localparam int          PSW_BANK_LO     = 3;
   localparam logic [7:0]  PSW_RESET       = 8'h00;
   localparam logic [1:0]  BANK_RESET      = 2'h0;
   localparam logic [7:0]  BYTE_ZERO       = 8'h00;
   localparam int          RAM_SMALL_BYTES = 128;
   localparam int          RAM_LARGE_BYTES = 256;
   localparam int          KB_BYTES        = 1024;

   // access kinds on the internal data port
   typedef enum logic [2:0] {
      DMM_ACC_DIRECT,
      DMM_ACC_INDIRECT,
      DMM_ACC_REG,
      DMM_ACC_BIT,
      DMM_ACC_PUSH,
      DMM_ACC_POP
   } dmm_acc_e;

   // region that an internal address falls in
   typedef enum logic [2:0] {
      DMM_REG_BANK,
      DMM_REG_BITSEG,
      DMM_REG_SCRATCH,
      DMM_REG_UPPER_RAM,
      DMM_REG_PERIPH
   } dmm_region_e;
endpackage

// >>> verilog/dmm_prog_decode.sv
// program memory decoder: on-chip or external selection
// assumes a registered fetch address from the core on sys_clk
`timescale 1ns/1ps
module dmm_prog_decode #(
   parameter int ONCHIP_KB = dmm_pkg::ONCHIP_SMALL_KB
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   input  wire logic        onchip_enable,
   output logic             onchip_sel,
   output logic             external_sel
);
   localparam logic [16:0] ONCHIP_LIMIT = 17'(ONCHIP_KB * dmm_pkg::KB_BYTES);
   logic low_hit;

   // fetch falls inside the on-chip part
   assign low_hit = onchip_enable && ({1'b0, fetch_addr} < ONCHIP_LIMIT);

   // lowest part on chip, rest external
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         onchip_sel   <= 1'b0;
         external_sel <= 1'b0;
      end else begin
         onchip_sel   <= fetch_req && low_hit; // RULE2
         external_sel <= fetch_req && !low_hit; // RULE2
      end
   end
endmodule

// >>> verilog/dmm_ram.sv
// internal data ram with byte and single-bit write
// assumes one access per cycle; read data registered
`timescale 1ns/1ps
module dmm_ram #(
   parameter int DEPTH = 256
) (
   input  wire logic       sys_clk,
   input  wire logic       we,
   input  wire logic       bit_we,
   input  wire logic [7:0] addr,
   input  wire logic [2:0] bit_pos,
   input  wire logic [7:0] wdata,
   input  wire logic       bit_val,
   output logic      [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   // byte and bit writes share storage, reads see both
   always_ff @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end else if (bit_we) begin
         mem[addr][bit_pos] <= bit_val;
      end
      rdata <= mem[addr];
   end
endmodule

// >>> verilog/dmm_top.sv
// memory address map of the core: internal ram, stack, banks, bits
// assumes a core issuing at most one access per cycle on sys_clk
//
// Summary of operation
// RULE1: program and data spaces are separate, program space is 64 kB.
// RULE2: low 4 kB (8 kB large variant) of program space are on chip.
// RULE3: 64 kB external data is reached only by the external move.
// RULE4: internal ram is 128 bytes, 256 in the large variant.
// RULE5: below 80h direct and indirect reach the same ram byte.
// RULE6: at 80h-FFh direct hits peripherals, indirect hits upper ram.
// RULE7: push and pop are indirect, so reach upper ram, not peripherals.
// RULE8: four banks of eight registers occupy bytes 00h to 1Fh.
// RULE9: reset selects bank 0.
// RULE10: stack pointer resets to 07h and increments before a push.
// RULE11: bytes 20h-2Fh hold 128 individually addressed bits 0-7Fh.
// RULE12: bit address maps to byte 20h plus addr/8, bit addr mod 8.
// RULE13: bit-segment bytes are also accessed as whole bytes.
// RULE14: bytes 30h-7Fh are plain storage without side effects.
// RULE15: status word bits 4 and 3 pick the active register bank.
`timescale 1ns/1ps
module dmm_top #(
   parameter bit LARGE = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        acc_req,
   input  wire logic [2:0]  acc_kind,
   input  wire logic        acc_write,
   input  wire logic [7:0]  acc_addr,
   input  wire logic [7:0]  acc_wdata,
   input  wire logic        acc_bit_val,
   input  wire logic        xdata_req,
   input  wire logic        xdata_write,
   input  wire logic [15:0] xdata_addr,
   input  wire logic [7:0]  xdata_wdata,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   input  wire logic        onchip_enable,
   input  wire logic        psw_we,
   input  wire logic [7:0]  psw_wdata,
   input  wire logic        sp_we,
   input  wire logic [7:0]  sp_wdata,
   input  wire logic [7:0]  periph_rdata,
   output logic      [7:0]  acc_rdata,
   output logic             acc_valid,
   output logic             acc_bit_rdata,
   output logic      [2:0]  acc_region,
   output logic             periph_req,
   output logic             periph_write,
   output logic      [7:0]  periph_addr,
   output logic      [7:0]  periph_wdata,
   output logic             ext_data_req,
   output logic             ext_data_write,
   output logic      [15:0] ext_data_addr,
   output logic      [7:0]  ext_data_wdata,
   output logic             prog_onchip_sel,
   output logic             prog_external_sel,
   output logic      [7:0]  stack_pointer,
   output logic      [1:0]  active_bank
);
   localparam int RAM_BYTES = LARGE ? dmm_pkg::RAM_LARGE_BYTES
                                    : dmm_pkg::RAM_SMALL_BYTES;
   localparam int PROG_KB   = LARGE ? dmm_pkg::ONCHIP_LARGE_KB
                                    : dmm_pkg::ONCHIP_SMALL_KB;

   // bit address to byte address within the bit segment
   function automatic logic [7:0] bit_byte(input logic [7:0] ba);
      bit_byte = dmm_pkg::BIT_SEG_BASE + {4'h0, ba[6:3]}; // RULE12
   endfunction

   // bank number from the two select bits of a status word
   function automatic logic [1:0] bank_of(input logic [7:0] sw);
      bank_of = {sw[dmm_pkg::PSW_BANK_HI], sw[dmm_pkg::PSW_BANK_LO]};
   endfunction

   // region of a ram-side byte address for a given access path
   function automatic logic [2:0] region_of(input logic [7:0] a,
                                            input logic       direct);
      if (a >= dmm_pkg::UPPER_BASE)
         region_of = direct ? 3'(dmm_pkg::DMM_REG_PERIPH)
                            : 3'(dmm_pkg::DMM_REG_UPPER_RAM); // RULE6
      else if (a <= dmm_pkg::BANK_LAST)
         region_of = 3'(dmm_pkg::DMM_REG_BANK);
      else if (a <= dmm_pkg::BIT_SEG_LAST)
         region_of = 3'(dmm_pkg::DMM_REG_BITSEG);
      else
         region_of = 3'(dmm_pkg::DMM_REG_SCRATCH);
   endfunction

   // decode, ram and pending-answer state
   logic [7:0] psw_reg;
   logic [7:0] sp_reg;
   logic [7:0] sp_next;
   logic [7:0] ram_addr;
   logic [2:0] ram_bit;
   logic       ram_we;
   logic       ram_bit_we;
   logic       to_periph;
   logic       in_range;
   logic       is_direct;
   logic [2:0] region_next;
   logic       pend_reg;
   logic       pend_periph_reg;
   logic       pend_bit_reg;
   logic [2:0] pend_bitpos_reg;
   logic [7:0] ram_rdata;
   logic [1:0] bank_sel;
   dmm_pkg::dmm_acc_e kind;

   // access kind and the bank picked by the status word
   assign kind     = dmm_pkg::dmm_acc_e'(acc_kind);
   assign bank_sel = bank_of(psw_reg); // RULE15

   // status word holds the bank select bits
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         psw_reg <= dmm_pkg::PSW_RESET; // RULE9
      else if (psw_we)
         psw_reg <= psw_wdata;
   end

   // stack pointer: pre-increment on push, post-decrement on pop
   // a load from the core wins over a push or pop in the same cycle
   always_comb begin
      sp_next = sp_reg;
      if (sp_we)
         sp_next = sp_wdata;
      else if (acc_req && kind == dmm_pkg::DMM_ACC_PUSH)
         sp_next = sp_reg + 8'h01; // RULE10
      else if (acc_req && kind == dmm_pkg::DMM_ACC_POP)
         sp_next = sp_reg - 8'h01;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         sp_reg <= dmm_pkg::SP_RESET; // RULE10
      else
         sp_reg <= sp_next;
   end

   // address decode for one access
   always_comb begin
      ram_addr  = acc_addr;
      ram_bit   = 3'h0;
      is_direct = 1'b0;
      case (kind)
         dmm_pkg::DMM_ACC_DIRECT: begin
            is_direct = 1'b1; // RULE5
         end
         dmm_pkg::DMM_ACC_INDIRECT: begin
            is_direct = 1'b0; // RULE5
         end
         dmm_pkg::DMM_ACC_REG: begin
            ram_addr = {3'h0, bank_sel, acc_addr[2:0]}; // RULE8
         end
         dmm_pkg::DMM_ACC_BIT: begin
            // bit addresses 80h up belong to peripherals
            is_direct = acc_addr[7];
            ram_addr  = acc_addr[7] ? {acc_addr[7:3], 3'h0}
                                    : bit_byte(acc_addr); // RULE11
            ram_bit   = acc_addr[2:0]; // RULE12
         end
         dmm_pkg::DMM_ACC_PUSH: begin
            // pre-increment: the byte lands one above the pointer
            ram_addr = sp_reg + 8'h01; // RULE7
         end
         dmm_pkg::DMM_ACC_POP: begin
            ram_addr = sp_reg; // RULE7
         end
         default: begin
            is_direct = 1'b1;
         end
      endcase
   end

   // write gating: peripheral, out-of-range and pop accesses never write
   // small variant: indirect 80h up has no ram behind it, writes drop
   assign to_periph   = is_direct && ram_addr >= dmm_pkg::UPPER_BASE;
   assign in_range    = 9'(ram_addr) < 9'(RAM_BYTES); // RULE4
   assign region_next = region_of(ram_addr, is_direct);
   assign ram_we      = acc_req && acc_write && !to_periph && in_range &&
                        kind != dmm_pkg::DMM_ACC_BIT &&
                        kind != dmm_pkg::DMM_ACC_POP; // RULE14
   assign ram_bit_we  = acc_req && acc_write && !to_periph && in_range &&
                        kind == dmm_pkg::DMM_ACC_BIT; // RULE13

   // one shared array; the small variant leaves the top half unused
   dmm_ram #(
      .DEPTH  (dmm_pkg::RAM_LARGE_BYTES)
   ) u_ram (
      .sys_clk (sys_clk),
      .we      (ram_we),
      .bit_we  (ram_bit_we),
      .addr    (ram_addr),
      .bit_pos (ram_bit),
      .wdata   (acc_wdata),
      .bit_val (acc_bit_val),
      .rdata   (ram_rdata)
   );

   // peripheral side for direct access at 80h and up
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         periph_req   <= 1'b0;
         periph_write <= 1'b0;
         periph_addr  <= dmm_pkg::BYTE_ZERO;
         periph_wdata <= dmm_pkg::BYTE_ZERO;
      end else begin
         periph_req   <= acc_req && to_periph; // RULE6
         periph_write <= acc_req && to_periph && acc_write;
         periph_addr  <= ram_addr;
         periph_wdata <= acc_wdata;
      end
   end

   // track the access whose ram read returns next cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pend_reg        <= 1'b0;
         pend_periph_reg <= 1'b0;
         pend_bit_reg    <= 1'b0;
         pend_bitpos_reg <= 3'h0;
      end else begin
         pend_reg        <= acc_req;
         pend_periph_reg <= to_periph || !in_range;
         pend_bit_reg    <= kind == dmm_pkg::DMM_ACC_BIT;
         pend_bitpos_reg <= ram_bit;
      end
   end

   // region of the latest access, held until the next one
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         acc_region <= 3'(dmm_pkg::DMM_REG_BANK);
      else if (acc_req)
         acc_region <= region_next; // RULE6
   end

   // answer one cycle after ram read, two after request
   // peripheral data is taken while periph_req still stands
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc_valid     <= 1'b0;
         acc_rdata     <= dmm_pkg::BYTE_ZERO;
         acc_bit_rdata <= 1'b0;
      end else begin
         acc_valid <= pend_reg;
         if (pend_reg) begin
            acc_rdata <= pend_periph_reg ? periph_rdata : ram_rdata;
         end
         // bit answer only moves on a bit access
         if (pend_reg && pend_bit_reg) begin
            acc_bit_rdata <= pend_periph_reg
                             ? periph_rdata[pend_bitpos_reg]
                             : ram_rdata[pend_bitpos_reg]; // RULE13
         end
      end
   end

   // external data only via the external move port
   // the core's external move is the only source of these requests
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_data_req   <= 1'b0;
         ext_data_write <= 1'b0;
         ext_data_addr  <= 16'h0000;
         ext_data_wdata <= dmm_pkg::BYTE_ZERO;
      end else begin
         ext_data_req   <= xdata_req; // RULE3
         ext_data_write <= xdata_req && xdata_write;
         ext_data_addr  <= xdata_addr; // RULE1
         ext_data_wdata <= xdata_wdata;
      end
   end

   // visible stack pointer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         stack_pointer <= dmm_pkg::SP_RESET;
      else
         stack_pointer <= sp_next; // RULE10
   end

   // visible bank, new value on the same edge as a status word write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         active_bank <= dmm_pkg::BANK_RESET; // RULE9
      else
         active_bank <= psw_we ? bank_of(psw_wdata) : bank_sel; // RULE15
   end

   // program fetch routing, on chip below the variant's limit
   dmm_prog_decode #(
      .ONCHIP_KB (PROG_KB)
   ) u_prog (
      .sys_clk       (sys_clk),
      .rstn          (rstn),
      .fetch_req     (fetch_req),
      .fetch_addr    (fetch_addr),
      .onchip_enable (onchip_enable),
      .onchip_sel    (prog_onchip_sel),
      .external_sel  (prog_external_sel)
   ); // RULE1 RULE2
endmodule
